// *** verilog/acc_consts.svh ***
/*
  Constants of the conversion control block: register offsets, fields,
  reset values and timing counts. Assumes a 40 MHz system clock.
*/
// How it works
// - flag stays low for every sample inside the input span except at the bottom code
// - flag high at most negative code or 64 LSB above top code
// - with flag high, low sign bit means over, high means under
// - sleep input low stops everything, reference included
// - nap stops all functions except the reference
// - each falling edge of the start input begins a conversion
// - start edges are ignored while a conversion runs
// - busy output low for the whole conversion, high at its end
// - result word updates one cycle after busy rises
// - code transitions midway between LSBs, LSB is FS/16384
// - result is two's complement on fourteen outputs
// - conversion about 260 ns, acquisition 100 ns, 2.5 Msps
// - nap input low naps the converter, high wakes it
`ifndef ACC_CONSTS_SVH
`define ACC_CONSTS_SVH

// ----------------------------------------------------------------
// timing
// ----------------------------------------------------------------
`define ACC_CLK_PERIOD_NS 25
`define ACC_CONV_TIME_NS 260
`define ACC_ACQ_TIME_NS 100
`define ACC_NAP_WAKE_NS 200
`define ACC_SLEEP_WAKE_MS 10
`define ACC_CONV_CYC ((`ACC_CONV_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_ACQ_CYC ((`ACC_ACQ_TIME_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_NAP_WAKE_CYC ((`ACC_NAP_WAKE_NS + `ACC_CLK_PERIOD_NS - 1) / `ACC_CLK_PERIOD_NS)
`define ACC_SLEEP_WAKE_CYC ((`ACC_SLEEP_WAKE_MS * 1000000) / `ACC_CLK_PERIOD_NS)

// ----------------------------------------------------------------
// converter code space
// ----------------------------------------------------------------
`define ACC_CODE_W 14
`define ACC_IN_W 18
`define ACC_CODE_MAX 8191
`define ACC_CODE_MIN (-8192)
`define ACC_OVER_MARGIN 64

// ----------------------------------------------------------------
// register map
// ----------------------------------------------------------------
`define ACC_REG_CTRL 4'h0
`define ACC_REG_STATUS 4'h4
`define ACC_REG_RESULT 4'h8
`define ACC_REG_COUNT 4'hC
`define ACC_CTRL_START_BIT 0
`define ACC_CTRL_PIN_EN_BIT 1
`define ACC_CTRL_RESET 2'h2
`define ACC_ST_BUSY_BIT 0
`define ACC_ST_NAP_BIT 1
`define ACC_ST_SLEEP_BIT 2
`define ACC_ST_READY_BIT 3
`define ACC_ST_FLAG_BIT 4
`define ACC_ST_OVER_BIT 5
`define ACC_ST_UNDER_BIT 6
`define ACC_RES_FLAG_BIT 14

`endif

// *** verilog/acc_pkg.sv ***
/*
  Types of the conversion control block.
  Assumes acc_consts.svh for all numeric constants.
*/
package acc_pkg;

  // ----------------------------------------------------------------
  // conversion sequencer states
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_IDLE = 2'b00,
    ACC_CONV = 2'b01,
    ACC_UPD = 2'b10
  } acc_state_t;

  // ----------------------------------------------------------------
  // power modes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ACC_PWR_ON = 2'b00,
    ACC_PWR_NAP = 2'b01,
    ACC_PWR_SLEEP = 2'b10
  } acc_pwr_t;

endpackage

// *** verilog/acc_sync.sv ***
/*
  Two flip-flop synchroniser for a group of pin inputs.
  Assumes inputs are asynchronous to CLOCK_I; reset level is a parameter.
*/
`timescale 1ns/1ps
module acc_sync #(
  parameter int W = 3,
  parameter logic [W-1:0] INIT = '1
) (
  // clock and reset
  input wire logic clk_i,
  input wire logic rst_n_i,
  // pins in, synchronised out
  input wire logic [W-1:0] d_i,
  output logic [W-1:0] q_o
);

  logic [W-1:0] meta_r;

  genvar g;
  generate
    for (g = 0; g < W; g = g + 1) begin : g_bit
      always_ff @(posedge clk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
          meta_r[g] <= INIT[g];
          q_o[g] <= INIT[g];
        end else begin
          meta_r[g] <= d_i[g];
          q_o[g] <= meta_r[g];
        end
      end
    end
  endgenerate

endmodule

// *** verilog/acc_quant.sv ***
/*
  Quantiser: turns a half-LSB sample into a 14-bit two's complement code
  and a range flag. Assumes the sample is already referred to bipolar zero.
*/
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_quant (
  // sample in half-LSB units, relative to bipolar zero
  input wire logic signed [`ACC_IN_W-1:0] sample_i,
  // result
  output logic [`ACC_CODE_W-1:0] code_o,
  output logic flag_o
);

  localparam logic signed [`ACC_IN_W-1:0] MAXV = `ACC_IN_W'(`ACC_CODE_MAX);
  localparam logic signed [`ACC_IN_W-1:0] MINV = `ACC_IN_W'(`ACC_CODE_MIN);
  localparam logic signed [`ACC_IN_W-1:0] OVERV = `ACC_IN_W'(`ACC_CODE_MAX + `ACC_OVER_MARGIN);

  logic signed [`ACC_IN_W:0] sum;
  logic signed [`ACC_IN_W-1:0] rounded;

  // transitions at half-LSB points: round half up
  always_comb begin
    sum = {sample_i[`ACC_IN_W-1], sample_i} + (`ACC_IN_W+1)'(1);
    rounded = sum[`ACC_IN_W:1];
    if (rounded > MAXV) begin
      code_o = MAXV[`ACC_CODE_W-1:0];
    end else if (rounded < MINV) begin
      code_o = MINV[`ACC_CODE_W-1:0];
    end else begin
      code_o = rounded[`ACC_CODE_W-1:0];
    end
    // low inside the span, high at bottom code or 64 LSB over top
    flag_o = (rounded <= MINV) || (rounded >= OVERV);
  end

endmodule

// *** verilog/acc_top.sv ***
/*
  Conversion control of a 14-bit parallel converter: start handshake,
  busy, result and range flag, sleep and nap, Wishbone register view.
  Assumes a 40 MHz clock, pins asynchronous, sample held by the front end.
*/
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_top #(
  parameter int CONV_CYC = `ACC_CONV_CYC,
  parameter int NAP_WAKE_CYC = `ACC_NAP_WAKE_CYC,
  parameter int SLEEP_WAKE_CYC = `ACC_SLEEP_WAKE_CYC
) (
  // clock and reset
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  // control pins
  input wire logic CONV_START_N_I,
  input wire logic NAP_N_I,
  input wire logic DEEP_SHUTDOWN_N_I,
  // analog front end sample, half-LSB units
  input wire logic signed [`ACC_IN_W-1:0] SAMPLE_I,
  // result pins
  output logic [`ACC_CODE_W-1:0] RESULT_WORD_O,
  output logic RANGE_EXCEEDED_FLAG_O,
  output logic BUSY_N_O,
  // power domain controls
  output logic REF_ACTIVE_O,
  output logic CORE_ACTIVE_O,
  output logic WAKE_READY_O,
  // wishbone slave
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  output logic [31:0] WB_DAT_O,
  output logic WB_ACK_O
);

  // ----------------------------------------------------------------
  // pin synchronisation
  // ----------------------------------------------------------------
  logic [2:0] pins_s;
  logic start_n_s;
  logic nap_n_s;
  logic sleep_n_s;

  acc_sync #(.W(3), .INIT(3'b111)) u_sync (
    .clk_i(CLOCK_I),
    .rst_n_i(RESETN_I),
    .d_i({DEEP_SHUTDOWN_N_I, NAP_N_I, CONV_START_N_I}),
    .q_o(pins_s)
  );

  assign start_n_s = pins_s[0];
  assign nap_n_s = pins_s[1];
  assign sleep_n_s = pins_s[2];

  // ----------------------------------------------------------------
  // power mode
  // ----------------------------------------------------------------
  acc_pkg::acc_pwr_t pwr_r;
  acc_pkg::acc_pwr_t pwr_nxt;
  logic [19:0] wake_cnt_r;
  logic wake_ready_r;

  always_comb begin
    if (!sleep_n_s) begin
      pwr_nxt = acc_pkg::ACC_PWR_SLEEP;
    end else if (!nap_n_s) begin
      pwr_nxt = acc_pkg::ACC_PWR_NAP;
    end else begin
      pwr_nxt = acc_pkg::ACC_PWR_ON;
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pwr_r <= acc_pkg::ACC_PWR_ON;
    end else begin
      pwr_r <= pwr_nxt;
    end
  end

  // wake-up timer: reports when results are trustworthy again
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      wake_cnt_r <= 20'h0_0000;
      wake_ready_r <= 1'b1;
    end else if (pwr_r == acc_pkg::ACC_PWR_SLEEP && pwr_nxt == acc_pkg::ACC_PWR_ON) begin
      wake_cnt_r <= 20'(SLEEP_WAKE_CYC - 1);
      wake_ready_r <= 1'b0;
    end else if (pwr_r == acc_pkg::ACC_PWR_NAP && pwr_nxt == acc_pkg::ACC_PWR_ON) begin
      wake_cnt_r <= 20'(NAP_WAKE_CYC - 1);
      wake_ready_r <= 1'b0;
    end else if (pwr_nxt != acc_pkg::ACC_PWR_ON) begin
      wake_cnt_r <= 20'h0_0000;
      wake_ready_r <= 1'b0;
    end else if (wake_cnt_r != 20'h0_0000) begin
      wake_cnt_r <= wake_cnt_r - 20'h0_0001;
    end else begin
      wake_ready_r <= 1'b1;
    end
  end

  // reference runs in nap, stops only in sleep
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      REF_ACTIVE_O <= 1'b1;
      CORE_ACTIVE_O <= 1'b1;
      WAKE_READY_O <= 1'b1;
    end else begin
      REF_ACTIVE_O <= (pwr_nxt != acc_pkg::ACC_PWR_SLEEP);
      CORE_ACTIVE_O <= (pwr_nxt == acc_pkg::ACC_PWR_ON);
      WAKE_READY_O <= wake_ready_r;
    end
  end

  // ----------------------------------------------------------------
  // start detection
  // ----------------------------------------------------------------
  logic start_n_d_r;
  logic soft_start_r;
  logic pin_en_r;
  logic start_req;

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      start_n_d_r <= 1'b1;
    end else begin
      start_n_d_r <= start_n_s;
    end
  end

  assign start_req = (pin_en_r && start_n_d_r && !start_n_s) || soft_start_r;

  // ----------------------------------------------------------------
  // conversion sequencer
  // ----------------------------------------------------------------
  acc_pkg::acc_state_t state_r;
  logic [7:0] conv_cnt_r;
  logic signed [`ACC_IN_W-1:0] held_r;
  logic [`ACC_CODE_W-1:0] q_code;
  logic q_flag;
  logic [15:0] done_cnt_r;

  acc_quant u_quant (
    .sample_i(held_r),
    .code_o(q_code),
    .flag_o(q_flag)
  );

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      state_r <= acc_pkg::ACC_IDLE;
      conv_cnt_r <= 8'h00;
      held_r <= '0;
      BUSY_N_O <= 1'b1;
    end else if (pwr_nxt != acc_pkg::ACC_PWR_ON) begin
      // shutdown aborts any conversion
      state_r <= acc_pkg::ACC_IDLE;
      conv_cnt_r <= 8'h00;
      BUSY_N_O <= 1'b1;
    end else begin
      case (state_r)
        acc_pkg::ACC_IDLE: begin
          if (start_req) begin
            held_r <= SAMPLE_I;
            conv_cnt_r <= 8'(CONV_CYC - 1);
            BUSY_N_O <= 1'b0;
            state_r <= acc_pkg::ACC_CONV;
          end
        end
        acc_pkg::ACC_CONV: begin
          // further starts are not looked at here
          if (conv_cnt_r == 8'h00) begin
            BUSY_N_O <= 1'b1;
            state_r <= acc_pkg::ACC_UPD;
          end else begin
            conv_cnt_r <= conv_cnt_r - 8'h01;
          end
        end
        acc_pkg::ACC_UPD: begin
          state_r <= acc_pkg::ACC_IDLE;
        end
        default: begin
          state_r <= acc_pkg::ACC_IDLE;
        end
      endcase
    end
  end

  // outputs change one cycle after busy rises
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      RESULT_WORD_O <= 14'h0000;
      RANGE_EXCEEDED_FLAG_O <= 1'b0;
      done_cnt_r <= 16'h0000;
    end else if (state_r == acc_pkg::ACC_UPD) begin
      RESULT_WORD_O <= q_code;
      RANGE_EXCEEDED_FLAG_O <= q_flag;
      done_cnt_r <= done_cnt_r + 16'h0001;
    end
  end

  // ----------------------------------------------------------------
  // wishbone slave
  // ----------------------------------------------------------------
  logic wb_req;
  logic wb_wr;
  logic over;
  logic under;

  assign wb_req = WB_CYC_I && WB_STB_I && !WB_ACK_O;
  assign wb_wr = wb_req && WB_WE_I && WB_SEL_I[0];
  // direction of an out-of-range result
  assign over = RANGE_EXCEEDED_FLAG_O && !RESULT_WORD_O[`ACC_CODE_W-1];
  assign under = RANGE_EXCEEDED_FLAG_O && RESULT_WORD_O[`ACC_CODE_W-1];

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      pin_en_r <= 1'(`ACC_CTRL_RESET >> `ACC_CTRL_PIN_EN_BIT);
      soft_start_r <= 1'b0;
    end else begin
      soft_start_r <= 1'b0;
      if (wb_wr && WB_ADR_I == `ACC_REG_CTRL) begin
        pin_en_r <= WB_DAT_I[`ACC_CTRL_PIN_EN_BIT];
        soft_start_r <= WB_DAT_I[`ACC_CTRL_START_BIT];
      end
    end
  end

  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) begin
      WB_ACK_O <= 1'b0;
      WB_DAT_O <= 32'h0000_0000;
    end else begin
      WB_ACK_O <= wb_req;
      WB_DAT_O <= 32'h0000_0000;
      if (wb_req && !WB_WE_I) begin
        if (WB_ADR_I == `ACC_REG_CTRL) begin
          WB_DAT_O[`ACC_CTRL_PIN_EN_BIT] <= pin_en_r;
        end else if (WB_ADR_I == `ACC_REG_STATUS) begin
          WB_DAT_O[`ACC_ST_BUSY_BIT] <= !BUSY_N_O;
          WB_DAT_O[`ACC_ST_NAP_BIT] <= (pwr_r == acc_pkg::ACC_PWR_NAP);
          WB_DAT_O[`ACC_ST_SLEEP_BIT] <= (pwr_r == acc_pkg::ACC_PWR_SLEEP);
          WB_DAT_O[`ACC_ST_READY_BIT] <= wake_ready_r;
          WB_DAT_O[`ACC_ST_FLAG_BIT] <= RANGE_EXCEEDED_FLAG_O;
          WB_DAT_O[`ACC_ST_OVER_BIT] <= over;
          WB_DAT_O[`ACC_ST_UNDER_BIT] <= under;
        end else if (WB_ADR_I == `ACC_REG_RESULT) begin
          WB_DAT_O[`ACC_CODE_W-1:0] <= RESULT_WORD_O;
          WB_DAT_O[`ACC_RES_FLAG_BIT] <= RANGE_EXCEEDED_FLAG_O;
        end else if (WB_ADR_I == `ACC_REG_COUNT) begin
          WB_DAT_O[15:0] <= done_cnt_r;
        end
      end
    end
  end

endmodule

// *** dv/acc_top_assertions.sv ***
/*
  Port-level checks of acc_top, bound in at the foot of this file.
  Assumes acc_consts.svh on the include path.
*/
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_top_checker #(
  parameter int CONV_CYC = 11
) (
  // clock, reset and pins
  input wire logic CLOCK_I,
  input wire logic RESETN_I,
  input wire logic CONV_START_N_I,
  input wire logic NAP_N_I,
  input wire logic DEEP_SHUTDOWN_N_I,
  // results and power
  input wire logic [`ACC_CODE_W-1:0] RESULT_WORD_O,
  input wire logic RANGE_EXCEEDED_FLAG_O,
  input wire logic BUSY_N_O,
  input wire logic REF_ACTIVE_O,
  input wire logic CORE_ACTIVE_O,
  // bus
  input wire logic WB_CYC_I,
  input wire logic WB_STB_I,
  input wire logic WB_WE_I,
  input wire logic [3:0] WB_ADR_I,
  input wire logic [3:0] WB_SEL_I,
  input wire logic [31:0] WB_DAT_I,
  input wire logic WB_ACK_O
);
  int busy_cnt_r;
  logic pin_on_r;
  default clocking @(posedge CLOCK_I); endclocking
  default disable iff (!RESETN_I);
  // cycles spent busy
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) busy_cnt_r <= 0;
    else busy_cnt_r <= BUSY_N_O ? 0 : busy_cnt_r + 1;
  end
  // pin start enable as last written over the bus
  always_ff @(posedge CLOCK_I or negedge RESETN_I) begin
    if (!RESETN_I) pin_on_r <= 1'b1;
    else if (WB_CYC_I && WB_STB_I && !WB_ACK_O && WB_WE_I && WB_SEL_I[0]
      && WB_ADR_I == `ACC_REG_CTRL) pin_on_r <= WB_DAT_I[`ACC_CTRL_PIN_EN_BIT];
  end
  AST_BUSY_LEN: assert property ($rose(BUSY_N_O) |-> busy_cnt_r == CONV_CYC || !CORE_ACTIVE_O)
    else $error("busy low time wrong");
  AST_DATA_LAG: assert property ($rose(BUSY_N_O) |-> $stable(RESULT_WORD_O))
    else $error("result changed with busy rise");
  AST_UPD_ONLY: assert property ($changed(RESULT_WORD_O) || $changed(RANGE_EXCEEDED_FLAG_O)
    |-> $past(BUSY_N_O) && !$past(BUSY_N_O, 2)) else $error("result changed off update");
  AST_START: assert property ($fell(CONV_START_N_I) && BUSY_N_O && CORE_ACTIVE_O && NAP_N_I
    && DEEP_SHUTDOWN_N_I && pin_on_r |-> ##[3:5] $fell(BUSY_N_O)) else $error("start not taken");
  AST_FLAG: assert property (RANGE_EXCEEDED_FLAG_O |-> RESULT_WORD_O == 14'h2000
    || RESULT_WORD_O == 14'h1fff) else $error("flag without extreme code");
  AST_SLEEP: assert property (!DEEP_SHUTDOWN_N_I [*5] |-> !REF_ACTIVE_O && !CORE_ACTIVE_O)
    else $error("sleep not entered");
  AST_NAP: assert property ((!NAP_N_I && DEEP_SHUTDOWN_N_I) [*5]
    |-> REF_ACTIVE_O && !CORE_ACTIVE_O) else $error("nap state wrong");
  AST_QUIET: assert property (!CORE_ACTIVE_O && !$past(CORE_ACTIVE_O) |-> BUSY_N_O)
    else $error("busy while powered down");
  AST_WB_ACK: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
    else $error("no ack");
  AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
    else $error("ack longer than one cycle");
endmodule

bind acc_top acc_top_checker #(.CONV_CYC(CONV_CYC)) u_acc_chk (.CLOCK_I, .RESETN_I,
  .CONV_START_N_I, .NAP_N_I, .DEEP_SHUTDOWN_N_I, .RESULT_WORD_O, .RANGE_EXCEEDED_FLAG_O,
  .BUSY_N_O, .REF_ACTIVE_O, .CORE_ACTIVE_O, .WB_CYC_I, .WB_STB_I, .WB_WE_I, .WB_ADR_I,
  .WB_SEL_I, .WB_DAT_I, .WB_ACK_O);

// *** dv/acc_host_model.sv ***
/*
  Host that captures conversion results and decodes the range flag.
  Assumes the busy and result pins of acc_top.
*/
`timescale 1ns/1ps
`include "acc_consts.svh"
module acc_host_model (
  input wire logic busy_n_i,
  input wire logic [`ACC_CODE_W-1:0] word_i,
  input wire logic flag_i,
  output logic [`ACC_CODE_W-1:0] word_o,
  output logic flag_o,
  output logic over_o,
  output logic under_o
);
  // latch at busy fall: previous result
  always @(negedge busy_n_i) begin
    word_o <= word_i;
    flag_o <= flag_i;
  end
  assign over_o = flag_o & ~word_o[`ACC_CODE_W-1];
  assign under_o = flag_o & word_o[`ACC_CODE_W-1];
endmodule

// *** dv/tb_top.sv ***
/*
  Self-checking bench of acc_top with a host model.
  Assumes acc_consts.svh on the include path.
*/
`timescale 1ns/1ps
`include "acc_consts.svh"
module tb_top;
  localparam int SLEEP_W = 20;
  logic clk, rst_n, start_n, nap_n, slp_n, cyc, stb, we, ack, busy_n, ref_on, core_on, rdy;
  logic flag, h_flag, h_over, h_under, ef, pf;
  logic [3:0] adr, sel;
  logic [31:0] dw, dr, rd;
  logic signed [`ACC_IN_W-1:0] smp;
  logic [`ACC_CODE_W-1:0] word, h_word, ec, pc;
  int num_errors = 0, n_compared = 0, ncv = 0, cyc_cnt = 0;
  int bnd[8] = '{-131072, -16385, -16383, 0, 16381, 16508, 16509, 131071};
  int oor[2] = '{16600, -20000};

  acc_top #(.SLEEP_WAKE_CYC(SLEEP_W)) uut (.CLOCK_I(clk), .RESETN_I(rst_n),
    .CONV_START_N_I(start_n), .NAP_N_I(nap_n), .DEEP_SHUTDOWN_N_I(slp_n), .SAMPLE_I(smp),
    .RESULT_WORD_O(word), .RANGE_EXCEEDED_FLAG_O(flag), .BUSY_N_O(busy_n),
    .REF_ACTIVE_O(ref_on), .CORE_ACTIVE_O(core_on), .WAKE_READY_O(rdy), .WB_CYC_I(cyc),
    .WB_STB_I(stb), .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(dw),
    .WB_DAT_O(dr), .WB_ACK_O(ack));
  acc_host_model u_host (.busy_n_i(busy_n), .word_i(word), .flag_i(flag), .word_o(h_word),
    .flag_o(h_flag), .over_o(h_over), .under_o(h_under));

  initial begin
    clk = 1'b0;
    forever #12.5 clk = ~clk;
  end
  always @(posedge clk) begin
    cyc_cnt++;
    if (cyc_cnt > 5000) begin
      num_errors++;
      end_of_test();
    end
  end

  task automatic end_of_test;
    $display("compared %0d errors %0d", n_compared, num_errors);
    if (num_errors == 0 && n_compared > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task automatic chk32(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t word got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic chk1(input logic got, input logic exp);
    n_compared++;
    if (got !== exp) begin
      num_errors++;
      $display("ERROR %0t bit got %b expected %b", $time, got, exp);
    end
  endtask
  task automatic tk(input int n);
    repeat (n) @(posedge clk);
  endtask
  task automatic wbusy(input logic v);
    while (busy_n !== v) @(posedge clk);
  endtask
  // classic single cycle, held until ack
  task automatic wb(input logic w, input logic [3:0] a, input logic [31:0] d);
    @(posedge clk);
    cyc <= 1'b1; stb <= 1'b1; we <= w; adr <= a; dw <= d;
    @(posedge clk);
    while (ack !== 1'b1) @(posedge clk);
    rd = dr;
    cyc <= 1'b0; stb <= 1'b0; we <= 1'b0;
  endtask
  // one conversion by pin or register, second start while busy
  task automatic conv(input int s, input logic pin);
    int r;
    r = (s + 1) >>> 1;
    ef = (r <= -8192 || r >= 8191 + `ACC_OVER_MARGIN);
    if (r > 8191) r = 8191;
    if (r < -8192) r = -8192;
    ec = r[13:0];
    @(posedge clk);
    smp <= s[17:0];
    if (pin) begin
      start_n <= 1'b0;
      tk(3);
      start_n <= 1'b1;
    end else wb(1'b1, 4'h0, 32'h0000_0003);
    wbusy(1'b0);
    chk32(32'(h_word), 32'(pc));
    chk1(h_over, pf & ~pc[13]);
    chk1(h_under, pf & pc[13]);
    chk1(h_flag, pf);
    start_n <= 1'b0;
    smp <= 18'($urandom);
    tk(2);
    start_n <= 1'b1;
    wbusy(1'b1);
    chk32(32'(word), 32'(pc));
    tk(1);
    chk32(32'(word), 32'(ec));
    chk1(flag, ef);
    pc = ec;
    pf = ef;
    ncv++;
  endtask

  initial begin
    rst_n = 1'b0; start_n = 1'b1; nap_n = 1'b1; slp_n = 1'b1; cyc = 1'b0; stb = 1'b0;
    we = 1'b0; adr = 4'h0; sel = 4'hf; dw = 32'h0000_0000; smp = '0; pc = '0; pf = 1'b0;
    void'($urandom(32'h8a83_59fa));
    tk(10);
    rst_n <= 1'b1;
    wb(1'b0, 4'h0, 32'h0000_0000);
    chk32(rd, 32'h0000_0002);
    wb(1'b0, 4'h2, 32'h0000_0000);
    chk32(rd, 32'h0000_0000);
    tk(3);
    foreach (bnd[i]) conv(bnd[i], 1'b1);
    repeat (6) conv($urandom_range(0, 262143) - 131072, 1'($urandom_range(0, 1)));
    foreach (oor[i]) begin
      conv(oor[i], 1'b0);
      wb(1'b0, 4'h8, 32'h0000_0000);
      chk32(rd, 32'({ef, ec}));
      wb(1'b0, 4'h4, 32'h0000_0000);
      chk32(rd, 32'({ef & ec[13], ef & ~ec[13], ef, 1'b1, 3'b000}));
      wb(1'b0, 4'hC, 32'h0000_0000);
      chk32(rd, 32'(ncv));
    end
    // write with byte lane 0 off is ignored
    sel <= 4'h0;
    wb(1'b1, 4'h0, 32'h0000_0000);
    sel <= 4'hf;
    wb(1'b0, 4'h0, 32'h0000_0000);
    chk32(rd, 32'h0000_0002);
    // pin start disabled: a falling edge must not start
    wb(1'b1, 4'h0, 32'h0000_0000);
    wb(1'b0, 4'h0, 32'h0000_0000);
    chk32(rd, 32'h0000_0000);
    start_n <= 1'b0;
    tk(6);
    chk1(busy_n, 1'b1);
    start_n <= 1'b1;
    wb(1'b1, 4'h0, 32'h0000_0002);
    nap_n <= 1'b0;
    tk(6);
    chk1(ref_on, 1'b1);
    chk1(core_on, 1'b0);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk32(rd, 32'({pf & pc[13], pf & ~pc[13], pf, 4'b0010}));
    start_n <= 1'b0;
    tk(3);
    start_n <= 1'b1;
    tk(3);
    chk1(busy_n, 1'b1);
    tk(11);
    chk1(busy_n, 1'b1);
    slp_n <= 1'b0;
    tk(6);
    chk1(ref_on, 1'b0);
    chk1(core_on, 1'b0);
    wb(1'b0, 4'h4, 32'h0000_0000);
    chk32(rd, 32'({pf & pc[13], pf & ~pc[13], pf, 4'b0100}));
    slp_n <= 1'b1;
    nap_n <= 1'b1;
    tk(4);
    chk1(rdy, 1'b0);
    tk(SLEEP_W - 4);
    chk1(rdy, 1'b0);
    tk(10);
    chk1(rdy, 1'b1);
    nap_n <= 1'b0;
    tk(6);
    nap_n <= 1'b1;
    tk(`ACC_NAP_WAKE_CYC + 5);
    conv(100, 1'b1);
    end_of_test();
  end
endmodule
